/* File: core/bmc_pkg.sv */
// Shared constants and types for the basic mode control register block.
package bmc_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	localparam logic [ADDR_W-1:0] BASIC_MODE_CONTROL_ADDR = 5'h00;

	localparam int SPEED_BIT    = 13;
	localparam int AN_EN_BIT    = 12;
	localparam int RESTART_BIT  = 9;
	localparam int DUPLEX_BIT   = 8;
	localparam int COL_TEST_BIT = 7;

	localparam logic SPEED_RST    = 1'h1;
	localparam logic AN_EN_RST    = 1'h1;
	localparam logic RESTART_RST  = 1'h0;
	localparam logic DUPLEX_RST   = 1'h1;
	localparam logic COL_TEST_RST = 1'h0;

	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

	// Timing in picoseconds; cycle counts derive from the clock period.
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int BIT_TIME_100_PS = 10000;
	localparam int COL_ON_BITS     = 512;
	localparam int COL_OFF_BITS    = 4;
	// Longest times round down; the fast rate is the tighter bound.
	localparam int COL_ON_CYC  = (COL_ON_BITS * BIT_TIME_100_PS)
		/ CLK_PERIOD_PS;
	localparam int COL_OFF_CYC = (COL_OFF_BITS * BIT_TIME_100_PS)
		/ CLK_PERIOD_PS;

	// Cycles after reset before the filtered strap level is trusted.
	localparam logic [2:0] STRAP_SETTLE = 3'h5;
	localparam logic [2:0] SETTLE_ONE   = 3'h1;

	typedef struct packed
	{
		logic speed_100;
		logic an_enable;
		logic restart;
		logic duplex_full;
		logic col_test;
	} ctrl_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef enum
	{
		RESTART_IDLE,
		RESTART_PENDING
	} restart_state_t;

endpackage

/* File: core/pin_filter.sv */
// Three-stage synchroniser that accepts a pin level once two stages agree.
`timescale 1ns/1ps
module pin_filter
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);

	logic stage1;
	logic stage2;
	logic stage3;
	logic next_level;

	// The first stage feeds only the second, so a metastable value
	// never reaches the comparison.
	always_comb
	begin
		next_level = level;
		if (stage2 == stage3)
		begin
			next_level = stage3;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			stage1 <= 1'h0;
			stage2 <= 1'h0;
			stage3 <= 1'h0;
			level  <= 1'h0;
		end
		else
		begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
		end
	end

endmodule

/* File: core/basic_mode_control.sv */
// Basic mode control register: speed, negotiation enable, restart, duplex, collision test.
`timescale 1ns/1ps

module basic_mode_control
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire bmc_pkg::reg_req_t req,
	output logic [15:0]            rdata,
	input  wire logic              duplex_strap,
	input  wire logic              mii_tx_en,
	output logic                   mii_col,
	input  wire logic              an_started,
	input  wire logic              an_negotiated_full,
	input  wire logic              an_negotiated_100,
	output logic                   an_restart,
	output logic                   an_enable,
	output logic                   link_full_duplex,
	output logic                   link_speed_100
);

	localparam int col_on_max  = bmc_pkg::COL_ON_CYC;
	localparam int col_off_max = bmc_pkg::COL_OFF_CYC;
	// The on limit is longer than a delay range may span, so a counter
	// measures it instead.
	localparam int col_wait_w  = $clog2(col_on_max + 1);
	localparam logic [col_wait_w-1:0] col_wait_lim =
		col_wait_w'(col_on_max);

	bmc_pkg::ctrl_t          ctrl;
	bmc_pkg::ctrl_t          next_ctrl;
	bmc_pkg::restart_state_t rstate;
	bmc_pkg::restart_state_t next_rstate;
	logic [15:0]             next_rdata;
	logic                    next_col;
	logic                    next_full;
	logic                    next_speed;
	logic [2:0]              settle;
	logic [2:0]              next_settle;
	logic                    strap_done;
	logic                    next_strap_done;
	logic                    duplex_written;
	logic                    next_duplex_written;
	logic                    tx_level;
	logic                    strap_level;
	logic                    ctrl_wr;
	logic                    ctrl_rd;
	logic                    restart_set;
	logic [col_wait_w-1:0]   col_wait;
	logic [col_wait_w-1:0]   next_col_wait;

	function automatic logic hits_ctrl(input logic [4:0] addr);
		hits_ctrl = (addr == bmc_pkg::BASIC_MODE_CONTROL_ADDR);
	endfunction

	// Unimplemented upper bits and bits 6 to 0 read as zero.
	function automatic logic [15:0] pack_word(input bmc_pkg::ctrl_t c);
		logic [15:0] w;
		w = bmc_pkg::READ_ZERO;
		w[bmc_pkg::SPEED_BIT]    = c.speed_100;
		w[bmc_pkg::AN_EN_BIT]    = c.an_enable;
		w[bmc_pkg::RESTART_BIT]  = c.restart;
		w[bmc_pkg::DUPLEX_BIT]   = c.duplex_full;
		w[bmc_pkg::COL_TEST_BIT] = c.col_test;
		pack_word = w;
	endfunction

	pin_filter u_tx_filter
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (mii_tx_en),
		.level    (tx_level)
	);

	pin_filter u_strap_filter
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (duplex_strap),
		.level    (strap_level)
	);

	assign ctrl_wr = req.wr && hits_ctrl(req.addr);
	assign ctrl_rd = req.rd && hits_ctrl(req.addr);
	// The enable written in the same access gates the restart request.
	assign restart_set = ctrl_wr && req.wdata[bmc_pkg::RESTART_BIT]
		&& req.wdata[bmc_pkg::AN_EN_BIT];

	// Restart tracking: a new request outranks the engine's start pulse,
	// so a restart asked for in that very cycle is not lost.
	always_comb
	begin
		next_rstate = rstate;
		case (rstate)
			bmc_pkg::RESTART_IDLE:
			begin
				if (restart_set)
				begin
					next_rstate = bmc_pkg::RESTART_PENDING;
				end
			end
			bmc_pkg::RESTART_PENDING:
			begin
				if (an_started && !restart_set)
				begin
					next_rstate = bmc_pkg::RESTART_IDLE;
				end
			end
			default:
			begin
				next_rstate = bmc_pkg::RESTART_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rstate <= bmc_pkg::RESTART_IDLE;
		end
		else
		begin
			rstate <= next_rstate;
		end
	end

	// Control bits. A written 0 on bit 9 never reaches the restart state.
	always_comb
	begin
		next_ctrl = ctrl;
		next_duplex_written = duplex_written;
		if (ctrl_wr)
		begin
			next_ctrl.speed_100   = req.wdata[bmc_pkg::SPEED_BIT];
			next_ctrl.an_enable   = req.wdata[bmc_pkg::AN_EN_BIT];
			next_ctrl.duplex_full = req.wdata[bmc_pkg::DUPLEX_BIT];
			next_ctrl.col_test    = req.wdata[bmc_pkg::COL_TEST_BIT];
			next_duplex_written   = 1'h1;
		end
		else if (!strap_done && settle == bmc_pkg::STRAP_SETTLE
			&& !duplex_written)
		begin
			next_ctrl.duplex_full = strap_level;
		end
		next_ctrl.restart = (next_rstate == bmc_pkg::RESTART_PENDING);
	end

	// The strap is taken once, a few cycles after reset release, so the
	// filter has settled; an earlier software write keeps its value.
	always_comb
	begin
		next_settle = settle;
		next_strap_done = strap_done;
		if (!strap_done)
		begin
			if (settle == bmc_pkg::STRAP_SETTLE)
			begin
				next_strap_done = 1'h1;
			end
			else
			begin
				next_settle = settle + bmc_pkg::SETTLE_ONE;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl.speed_100   <= bmc_pkg::SPEED_RST;
			ctrl.an_enable   <= bmc_pkg::AN_EN_RST;
			ctrl.restart     <= bmc_pkg::RESTART_RST;
			ctrl.duplex_full <= bmc_pkg::DUPLEX_RST;
			ctrl.col_test    <= bmc_pkg::COL_TEST_RST;
			duplex_written   <= 1'h0;
			settle           <= 3'h0;
			strap_done       <= 1'h0;
		end
		else
		begin
			ctrl           <= next_ctrl;
			duplex_written <= next_duplex_written;
			settle         <= next_settle;
			strap_done     <= next_strap_done;
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_comb
	begin
		next_rdata = bmc_pkg::READ_ZERO;
		if (ctrl_rd)
		begin
			next_rdata = pack_word(ctrl);
		end
	end

	// Collision test follows the filtered transmit enable; a few cycles of
	// filter delay sit inside both limits at either line rate.
	always_comb
	begin
		next_col = ctrl.col_test && tx_level;
	end

	// Negotiation results win while it is enabled.
	always_comb
	begin
		if (ctrl.an_enable)
		begin
			next_full  = an_negotiated_full;
			next_speed = an_negotiated_100;
		end
		else
		begin
			next_full  = ctrl.duplex_full;
			next_speed = ctrl.speed_100;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rdata            <= bmc_pkg::READ_ZERO;
			mii_col          <= 1'h0;
			link_full_duplex <= bmc_pkg::DUPLEX_RST;
			link_speed_100   <= bmc_pkg::SPEED_RST;
		end
		else
		begin
			rdata            <= next_rdata;
			mii_col          <= next_col;
			link_full_duplex <= next_full;
			link_speed_100   <= next_speed;
		end
	end

	assign an_restart = ctrl.restart;
	assign an_enable  = ctrl.an_enable;

	// Cycles spent with transmit raised in test mode and no collision yet.
	always_comb
	begin
		next_col_wait = '0;
		if (!rst && ctrl.col_test && mii_tx_en && !mii_col)
		begin
			next_col_wait = col_wait + 1'h1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		col_wait <= next_col_wait;
	end

	chk_restart_set: assert property
		(@(posedge core_clk) disable iff (rst)
		restart_set |=> an_restart)
		else $error("restart request not raised");

	chk_restart_ignored: assert property
		(@(posedge core_clk) disable iff (rst)
		ctrl_wr && !req.wdata[bmc_pkg::AN_EN_BIT] && !an_restart
		|=> !an_restart)
		else $error("restart taken while negotiation disabled");

	chk_restart_hold: assert property
		(@(posedge core_clk) disable iff (rst)
		an_restart && !an_started |=> an_restart)
		else $error("restart bit cleared before start");

	chk_restart_clear: assert property
		(@(posedge core_clk) disable iff (rst)
		an_restart && an_started && !restart_set |=> !an_restart)
		else $error("restart bit not self cleared");

	chk_zero_write_kept: assert property
		(@(posedge core_clk) disable iff (rst)
		an_restart && ctrl_wr && !req.wdata[bmc_pkg::RESTART_BIT]
		&& !an_started |=> an_restart)
		else $error("written zero cancelled a restart");

	chk_duplex_forced: assert property
		(@(posedge core_clk) disable iff (rst)
		!ctrl.an_enable |=> link_full_duplex == $past(ctrl.duplex_full))
		else $error("forced duplex not applied");

	chk_col_rise: assert property
		(@(posedge core_clk) disable iff (rst)
		(mii_tx_en && ctrl.col_test)[*6] |-> mii_col)
		else $error("collision not raised in test mode");

	chk_col_latency: assert property
		(@(posedge core_clk) disable iff (rst)
		col_wait < col_wait_lim)
		else $error("collision too late");

	chk_col_fall: assert property
		(@(posedge core_clk) disable iff (rst)
		$fell(tx_level) |-> ##[1:col_off_max] !mii_col)
		else $error("collision not dropped in time");

	chk_reserved_zero: assert property
		(@(posedge core_clk) disable iff (rst)
		req.rd |=> rdata[6:0] == 7'h00)
		else $error("reserved bits read nonzero");

	chk_reset_values: assert property
		(@(posedge core_clk) disable iff (rst)
		$past(rst) |-> !an_restart && !ctrl.col_test && !mii_col)
		else $error("reset values wrong");

	chk_an_overrides: assert property
		(@(posedge core_clk) disable iff (rst)
		ctrl.an_enable |=> link_speed_100 == $past(an_negotiated_100)
		&& link_full_duplex == $past(an_negotiated_full))
		else $error("negotiation result not used");

	chk_read_word: assert property
		(@(posedge core_clk) disable iff (rst)
		ctrl_rd |=> rdata == pack_word($past(ctrl)))
		else $error("register read mismatch");

endmodule

/* File: tb/an_engine_model.sv */
// Behavioural negotiation engine that answers restart requests.
`timescale 1ns/1ps
module an_engine_model
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic stall,
	input  wire logic an_restart,
	output logic      an_started
);
	logic [3:0] wait_cnt;

	// One pulse per request after a short delay, so a pending request can
	// be watched; stall holds the engine off to model a slow start.
	always_ff @(posedge core_clk)
	begin
		an_started <= 1'b0;
		if (rst || !an_restart || stall)
			wait_cnt <= 4'h0;
		else if (wait_cnt == 4'h3)
		begin
			an_started <= 1'b1;
			wait_cnt   <= 4'h0;
		end
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule

/* File: tb/basic_mode_control_tb.sv */
// Self-checking bench for the basic mode control register block.
`timescale 1ns/1ps
module basic_mode_control_tb;
	logic              core_clk;
	logic              rst;
	bmc_pkg::reg_req_t req;
	logic [15:0]       rdata;
	logic              duplex_strap;
	logic              mii_tx_en;
	logic              mii_col;
	logic              an_started;
	logic              neg_full;
	logic              neg_100;
	logic              an_restart;
	logic              an_enable;
	logic              link_full_duplex;
	logic              link_speed_100;
	logic              stall;
	int                failures;
	int                checks_done;

	basic_mode_control u_dut
	(
		.core_clk           (core_clk),
		.rst                (rst),
		.req                (req),
		.rdata              (rdata),
		.duplex_strap       (duplex_strap),
		.mii_tx_en          (mii_tx_en),
		.mii_col            (mii_col),
		.an_started         (an_started),
		.an_negotiated_full (neg_full),
		.an_negotiated_100  (neg_100),
		.an_restart         (an_restart),
		.an_enable          (an_enable),
		.link_full_duplex   (link_full_duplex),
		.link_speed_100     (link_speed_100)
	);

	an_engine_model u_engine
	(
		.core_clk   (core_clk),
		.rst        (rst),
		.stall      (stall),
		.an_restart (an_restart),
		.an_started (an_started)
	);

	initial
	begin
		core_clk = 1'b0;
		forever
			#2.5 core_clk = ~core_clk;
	end

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic flags(input logic [3:0] exp);
		chk({12'h000, an_restart, an_enable, link_full_duplex,
			link_speed_100}, {12'h000, exp});
	endtask

	task automatic wait_col(input logic v, input int lim);
		int n;
		n = 0;
		while (mii_col !== v && n < lim)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		#1;
		chk({15'h0000, mii_col}, {15'h0000, v});
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		failures++;
		conclude();
	end

	initial
	begin
		failures = 0;
		checks_done = 0;
		rst = 1'b1;
		req = '0;
		duplex_strap = 1'b1;
		mii_tx_en = 1'b0;
		neg_full = 1'b1;
		neg_100 = 1'b1;
		stall = 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd(5'h00, 16'h3100);
		flags(4'h7);
		wr(5'h00, 16'h0000);
		rd(5'h00, 16'h0000);
		flags(4'h0);
		wr(5'h00, 16'h0200);
		rd(5'h00, 16'h0000);
		flags(4'h0);
		wr(5'h00, 16'h0100);
		rd(5'h00, 16'h0100);
		flags(4'h2);
		stall <= 1'b1;
		wr(5'h00, 16'h1200);
		rd(5'h00, 16'h1200);
		flags(4'hf);
		wr(5'h00, 16'h1000);
		rd(5'h00, 16'h1200);
		stall <= 1'b0;
		repeat (20) @(posedge core_clk);
		rd(5'h00, 16'h1000);
		@(posedge core_clk);
		neg_full <= 1'b1;
		neg_100 <= 1'b0;
		wr(5'h00, 16'h30ff);
		rd(5'h00, 16'h3080);
		flags(4'h6);
		wr(5'h01, 16'h0000);
		rd(5'h01, 16'h0000);
		rd(5'h00, 16'h3080);
		@(posedge core_clk);
		mii_tx_en <= 1'b1;
		wait_col(1'b1, bmc_pkg::COL_ON_CYC);
		repeat (30) @(posedge core_clk);
		chk({15'h0000, mii_col}, 16'h0001);
		mii_tx_en <= 1'b0;
		wait_col(1'b0, bmc_pkg::COL_OFF_CYC);
		wr(5'h00, 16'h1000);
		mii_tx_en <= 1'b1;
		repeat (40) @(posedge core_clk);
		chk({15'h0000, mii_col}, 16'h0000);
		mii_tx_en <= 1'b0;
		// A second reset with the strap low: bit 8 must follow the strap.
		@(posedge core_clk);
		duplex_strap <= 1'b0;
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd(5'h00, 16'h3000);
		flags(4'h6);
		conclude();
	end
endmodule
